// ==== src/usbd_defines.svh ====
// Constants shared by the USB descriptor/status device end and its controller end
`ifndef USBD_DEFINES_SVH
`define USBD_DEFINES_SVH

// ==========================================================================
// Register indices on the link between the ends
`define USBD_ADDR_BD        2'h0
`define USBD_ADDR_BUSCTL    2'h1
`define USBD_ADDR_ERR       2'h2

// ==========================================================================
// Descriptor status word fields
`define USBD_BD_OWN         15
`define USBD_BD_DTS         14
`define USBD_BD_PID_HI      13
`define USBD_BD_PID_LO      10
`define USBD_BD_BC_HI       9
`define USBD_BD_BC_LO       0

// ==========================================================================
// Bus control/status fields
`define USBD_BC_LIVE_J_LINE_STATE      7
`define USBD_BC_SE0         6
`define USBD_BC_TOKBSY      5
`define USBD_BC_RESET       4
`define USBD_BC_HOST_ROLE_ENABLE      3
`define USBD_BC_RESUME      2
`define USBD_BC_PPCLR       1
`define USBD_BC_FRAME_START_ENABLE       0
`define USBD_BC_WMASK       5'h1f

// ==========================================================================
// Error flag positions
`define USBD_ERR_BITSTUFF   7
`define USBD_ERR_OVERRUN    5
`define USBD_ERR_TURNAROUND 4
`define USBD_ERR_PARTIAL    3
`define USBD_ERR_CRC16      2
`define USBD_ERR_CRC5_EOF   1
`define USBD_ERR_PID        0
`define USBD_ERR_MASK       8'hbf

// ==========================================================================
// Controller register map on the software port
`define USBD_SW_CMD         2'h0
`define USBD_SW_BD          2'h1
`define USBD_SW_ERR         2'h2
`define USBD_SW_BUSCTL      2'h3

// ==========================================================================
// Timing
`define USBD_CLK_HZ         40000000
`define USBD_RESET_MS       50
`define USBD_RESUME_MS      10

`endif

// ==== src/usbd_pkg.sv ====
// Types shared by the USB descriptor/status device end and its controller end
package usbd_pkg;

    // ======================================================================
    // Controller sequencing states
    typedef enum logic [1:0] {
        USBD_ST_IDLE = 2'b01,
        USBD_ST_WAIT = 2'b10
    } usbd_state_e;

    typedef logic [15:0] usbd_word_t;

endpackage : usbd_pkg

// ==== src/usbd_if.sv ====
// Register link between the controller end and the device end
interface usbd_if;
    logic                  req_valid;
    logic                  req_ready;
    logic                  req_write;
    logic [1:0]            req_addr;
    usbd_pkg::usbd_word_t  req_wdata;
    logic                  rsp_valid;
    logic                  rsp_ready;
    usbd_pkg::usbd_word_t  rsp_data;

    modport dev (
        input  req_valid, req_write, req_addr, req_wdata, rsp_ready,
        output req_ready, rsp_valid, rsp_data
    );

    modport ctl (
        output req_valid, req_write, req_addr, req_wdata, rsp_ready,
        input  req_ready, rsp_valid, rsp_data
    );
endinterface : usbd_if

// ==== src/usbd_device.sv ====
// Device end: descriptor status word, live bus flags, bus control bits and error flags
//
// Behaviour
// R1: Engine-owned descriptor is never altered by software
// R2: Toggle flag selects DATA1 or DATA0
// R3: Engine records received or returned PID
// R4: Byte count loaded, then replaced by actual
// R5: Live J flag per bus speed
// R6: Live single-ended zero flag
// R7: Token busy flag while token executes
// R8: Reset bit drives reset, held 50 ms
// R9: Resume bit drives resume, held 10 ms
// R10: Bit stuffing violation sets its flag
// R11: Overrun truncates to count, sets flag
// R12: Turnaround time-out sets its flag
// R13: Partial byte data field sets flag
// R14: CRC16 failure sets its flag
// R15: Token CRC5 fail, or host end-of-frame
// R16: PID complement failure sets its flag
// R17: Word write of one clears flag
// R18: Never clear flags by read-modify-write
// R19: Flags stay set until software clears
`include "usbd_defines.svh"

module usbd_device (
    input  wire logic        i_clock,         // System clock
    input  wire logic        i_nrst,          // Asynchronous reset, active low
    usbd_if.dev              link,            // Register link from the controller
    input  wire logic        i_dp,            // D+ line level
    input  wire logic        i_dm,            // D- line level
    input  wire logic        i_low_speed,     // Bus runs at low speed
    input  wire logic        i_token_active,  // Engine is executing a token
    input  wire logic        i_xfer_done,     // Transfer complete pulse
    input  wire logic [3:0]  i_xfer_pid,      // PID or status of the transfer
    input  wire logic [10:0] i_xfer_bytes,    // Bytes actually moved or offered
    input  wire logic        i_err_bitstuff,  // Bit stuffing violation pulse
    input  wire logic        i_err_turnaround, // Turnaround time-out pulse
    input  wire logic        i_err_partial,   // Non-integral data field pulse
    input  wire logic        i_err_crc16,     // Data CRC failure pulse
    input  wire logic        i_err_crc5,      // Token CRC failure pulse
    input  wire logic        i_err_eof,       // End-of-frame error pulse
    input  wire logic        i_err_pid,       // PID check failure pulse
    output logic             o_owned,         // Engine owns the descriptor
    output logic             o_data1,         // Packet type is DATA1
    output logic [9:0]       o_byte_count,    // Descriptor byte count
    output logic             o_token_reject,  // Token dropped for CRC5 error
    output logic             o_reset_drive,   // Drive USB reset signalling
    output logic             o_resume_drive,  // Drive resume signalling
    output logic             o_host_en,       // Host role enabled
    output logic             o_pp_clear,      // Ping-pong pointers held clear
    output logic             o_sof_en         // Start-of-frame generation on
);

    // ======================================================================
    // State
    typedef struct packed {
        logic                        own;
        logic                        data_toggle_select;
        logic [3:0]                  pid;
        logic [9:0]                  bc;
        logic                        live_j_line_state;
        logic                        se0;
        logic                        tokbsy;
        logic [4:0]                  ctl;
        logic [7:0]                  err;
        logic                        reject;
        logic [1:0][15:0]            fifo;
        logic                        wptr;
        logic                        rptr;
        logic [1:0]                  count;
    } usbd_dev_s;

    usbd_dev_s st;
    usbd_dev_s next_st;

    logic                 take;
    logic                 wr_bd;
    logic                 wr_ctl;
    logic                 wr_err;
    logic                 push;
    logic                 pop;
    logic [15:0]          rd_word;
    logic [7:0]           err_set;
    logic [7:0]           err_clr;
    logic                 j_now;

    // ======================================================================
    // Link handshake
    // Ready drops only when both answer slots are taken, so a stalled
    // controller never loses a read answer.
    assign link.req_ready = (st.count != 2'h2) || pop;
    assign link.rsp_valid = (st.count != 2'h0);
    assign link.rsp_data  = st.fifo[st.rptr];

    assign take   = link.req_valid && link.req_ready;
    assign wr_bd  = take && link.req_write && (link.req_addr == `USBD_ADDR_BD);
    assign wr_ctl = take && link.req_write && (link.req_addr == `USBD_ADDR_BUSCTL);
    assign wr_err = take && link.req_write && (link.req_addr == `USBD_ADDR_ERR);
    assign push   = take && !link.req_write;
    assign pop    = link.rsp_valid && link.rsp_ready;

    // ======================================================================
    // Read word selection
    always_comb begin
        rd_word = 16'h0000;
        unique case (link.req_addr)
            `USBD_ADDR_BD: begin
                rd_word = {st.own, st.data_toggle_select, st.pid, st.bc};
            end
            `USBD_ADDR_BUSCTL: begin
                rd_word = {8'h00, st.live_j_line_state, st.se0, st.tokbsy, st.ctl};
            end
            `USBD_ADDR_ERR: begin
                rd_word = {8'h00, st.err};
            end
            default: begin
                rd_word = 16'h0000;
            end
        endcase
    end

    // ======================================================================
    // Error event collection
    always_comb begin
        err_set = 8'h00;
        err_set[`USBD_ERR_BITSTUFF]   = i_err_bitstuff;                        // R10
        err_set[`USBD_ERR_TURNAROUND] = i_err_turnaround;                      // R12
        err_set[`USBD_ERR_PARTIAL]    = i_err_partial;                         // R13
        err_set[`USBD_ERR_CRC16]      = i_err_crc16;                           // R14
        err_set[`USBD_ERR_CRC5_EOF]   = st.ctl[`USBD_BC_HOST_ROLE_ENABLE] ? i_err_eof : i_err_crc5; // R15
        err_set[`USBD_ERR_PID]        = i_err_pid;                             // R16
        err_set[`USBD_ERR_OVERRUN]    = i_xfer_done && st.own
                                        && (i_xfer_bytes > {1'b0, st.bc});     // R11
        err_clr = wr_err ? (link.req_wdata[7:0] & `USBD_ERR_MASK) : 8'h00;     // R17
    end

    // J is differential one at full speed and differential zero at low speed
    assign j_now = i_low_speed ? (!i_dp && i_dm) : (i_dp && !i_dm);           // R5

    // ======================================================================
    // Next state
    always_comb begin
        next_st = st;

        next_st.live_j_line_state = j_now;                                                // R5
        next_st.se0    = !i_dp && !i_dm;                                       // R6
        next_st.tokbsy = i_token_active;                                       // R7
        next_st.reject = i_err_crc5 && !st.ctl[`USBD_BC_HOST_ROLE_ENABLE];               // R15

        // Set wins over a clear in the same cycle; nothing else clears
        next_st.err = ((st.err & ~err_clr) | err_set) & `USBD_ERR_MASK;       // R17 R19

        if (wr_ctl) begin
            next_st.ctl = link.req_wdata[4:0] & `USBD_BC_WMASK;                // R8 R9
        end

        // Software may only touch the descriptor while it holds it
        if (wr_bd && !st.own) begin                                            // R1
            next_st.own = link.req_wdata[`USBD_BD_OWN];
            next_st.data_toggle_select = link.req_wdata[`USBD_BD_DTS];                        // R2
            next_st.pid = link.req_wdata[`USBD_BD_PID_HI:`USBD_BD_PID_LO];
            next_st.bc  = link.req_wdata[`USBD_BD_BC_HI:`USBD_BD_BC_LO];       // R4
        end

        // Completion hands the descriptor back with the actual count;
        // an overrun leaves the count at the limit the data was cut to
        if (i_xfer_done && st.own) begin
            next_st.own = 1'b0;                                                // R1
            next_st.pid = i_xfer_pid;                                          // R3
            if (i_xfer_bytes <= {1'b0, st.bc}) begin
                next_st.bc = i_xfer_bytes[9:0];                                // R4
            end else begin
                next_st.bc = st.bc;                                            // R11
            end
        end

        // Two-entry answer buffer
        if (push) begin
            next_st.fifo[st.wptr] = rd_word;
            next_st.wptr          = ~st.wptr;
        end
        if (pop) begin
            next_st.rptr = ~st.rptr;
        end
        unique case ({push, pop})
            2'b10: begin
                next_st.count = st.count + 2'h1;
            end
            2'b01: begin
                next_st.count = st.count - 2'h1;
            end
            default: begin
                next_st.count = st.count;
            end
        endcase
    end

    // ======================================================================
    // Registers
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ======================================================================
    // Outputs
    assign o_owned        = st.own;
    assign o_data1        = st.data_toggle_select;                                            // R2
    assign o_byte_count   = st.bc;
    assign o_token_reject = st.reject;
    assign o_reset_drive  = st.ctl[`USBD_BC_RESET];                            // R8
    assign o_resume_drive = st.ctl[`USBD_BC_RESUME];                           // R9
    assign o_host_en      = st.ctl[`USBD_BC_HOST_ROLE_ENABLE];
    assign o_pp_clear     = st.ctl[`USBD_BC_PPCLR];
    assign o_sof_en       = st.ctl[`USBD_BC_FRAME_START_ENABLE];

endmodule : usbd_device

// ==== src/usbd_ctrl.sv ====
// Controller end: software register port, timed reset/resume, polling of the device
//
// Our own choices: the plain strobed port and the address map.
`include "usbd_defines.svh"

module usbd_ctrl #(
    parameter int unsigned RESET_CYCLES  = `USBD_RESET_MS * (`USBD_CLK_HZ / 1000),
    parameter int unsigned RESUME_CYCLES = `USBD_RESUME_MS * (`USBD_CLK_HZ / 1000)
) (
    input  wire logic        i_clock,   // System clock
    input  wire logic        i_nrst,    // Asynchronous reset, active low
    usbd_if.ctl              link,      // Register link to the device
    input  wire logic [1:0]  i_addr,    // Software register index
    input  wire logic [15:0] i_wdata,   // Software write data
    input  wire logic        i_wr,      // Write strobe
    input  wire logic        i_rd,      // Read strobe
    output logic [15:0]      o_rdata    // Read data, one cycle after strobe
);

    // ======================================================================
    // State
    typedef struct packed {
        usbd_pkg::usbd_state_e       state;
        logic                        rst_on;
        logic                        res_on;
        logic [2:0]                  cfg;
        logic [31:0]                 timer;
        logic                        ctl_pend;
        logic                        bd_pend;
        logic [15:0]                 bd_word;
        logic                        err_pend;
        logic [7:0]                  err_mask;
        logic [1:0]                  poll;
        logic [1:0]                  wait_addr;
        logic [15:0]                 m_bd;
        logic [15:0]                 m_bus;
        logic [15:0]                 m_err;
        logic [15:0]                 rdata;
    } usbd_ctl_s;

    usbd_ctl_s st;
    usbd_ctl_s next_st;

    logic [15:0] ctl_word;

    // Command bits 4:3 are start-of-frame then pointer clear; the device wants them the other way round
    assign ctl_word = {11'h000, st.rst_on, st.cfg[2], st.res_on, st.cfg[0], st.cfg[1]};

    // ======================================================================
    // Request issue: pending writes first, otherwise poll the next register
    always_comb begin
        link.req_valid = 1'b0;
        link.req_write = 1'b0;
        link.req_addr  = `USBD_ADDR_BD;
        link.req_wdata = 16'h0000;
        if (st.state == usbd_pkg::USBD_ST_IDLE) begin
            link.req_valid = 1'b1;
            if (st.ctl_pend) begin
                link.req_write = 1'b1;
                link.req_addr  = `USBD_ADDR_BUSCTL;
                link.req_wdata = ctl_word;                                     // R8 R9
            end else if (st.err_pend) begin
                link.req_write = 1'b1;
                link.req_addr  = `USBD_ADDR_ERR;
                link.req_wdata = {8'h00, st.err_mask};                         // R18
            end else if (st.bd_pend) begin
                link.req_write = 1'b1;
                link.req_addr  = `USBD_ADDR_BD;
                link.req_wdata = st.bd_word;                                   // R4
            end else begin
                link.req_addr  = st.poll;
            end
        end
    end

    assign link.rsp_ready = (st.state == usbd_pkg::USBD_ST_WAIT);

    // ======================================================================
    // Next state
    always_comb begin
        next_st = st;

        // Software writes
        if (i_wr) begin
            unique case (i_addr)
                `USBD_SW_CMD: begin
                    next_st.cfg      = {i_wdata[2], i_wdata[4:3]};
                    next_st.ctl_pend = 1'b1;
                    if (i_wdata[0]) begin
                        next_st.rst_on = 1'b1;
                        next_st.res_on = 1'b0;
                        next_st.timer  = RESET_CYCLES;                         // R8
                    end else if (i_wdata[1]) begin
                        next_st.res_on = 1'b1;
                        next_st.rst_on = 1'b0;
                        next_st.timer  = RESUME_CYCLES;                        // R9
                    end
                end
                `USBD_SW_BD: begin
                    // Arming an engine-owned descriptor is refused
                    if (!st.m_bd[`USBD_BD_OWN]) begin                          // R1
                        next_st.bd_word = i_wdata;
                        next_st.bd_pend = 1'b1;
                    end
                end
                `USBD_SW_ERR: begin
                    // Only the bits software names are cleared, never a read-back
                    next_st.err_mask = i_wdata[7:0] & `USBD_ERR_MASK;         // R18
                    next_st.err_pend = 1'b1;
                end
                default: begin
                    next_st.ctl_pend = st.ctl_pend;
                end
            endcase
        end

        // Timed reset/resume: drop the bit when the hold time is over
        if ((st.rst_on || st.res_on) && !(i_wr && i_addr == `USBD_SW_CMD)) begin
            if (st.timer > 32'h1) begin
                next_st.timer = st.timer - 32'h1;
            end else begin
                next_st.rst_on   = 1'b0;                                       // R8
                next_st.res_on   = 1'b0;                                       // R9
                next_st.ctl_pend = 1'b1;
            end
        end

        unique case (st.state)
            usbd_pkg::USBD_ST_IDLE: begin
                if (link.req_ready) begin
                    if (st.ctl_pend) begin
                        // Stays pending for a new command or a hold time ending now
                        next_st.ctl_pend = (i_wr && i_addr == `USBD_SW_CMD)
                                           || ((st.rst_on || st.res_on) && st.timer <= 32'h1);
                    end else if (st.err_pend) begin
                        next_st.err_pend = i_wr && i_addr == `USBD_SW_ERR;
                    end else if (st.bd_pend) begin
                        next_st.bd_pend = i_wr && i_addr == `USBD_SW_BD && !st.m_bd[`USBD_BD_OWN];
                    end else begin
                        next_st.wait_addr = st.poll;
                        next_st.poll      = (st.poll == `USBD_ADDR_ERR) ? `USBD_ADDR_BD : st.poll + 2'h1;
                        next_st.state     = usbd_pkg::USBD_ST_WAIT;
                    end
                end
            end
            usbd_pkg::USBD_ST_WAIT: begin
                if (link.rsp_valid) begin
                    unique case (st.wait_addr)
                        `USBD_ADDR_BD: begin
                            next_st.m_bd = link.rsp_data;
                        end
                        `USBD_ADDR_BUSCTL: begin
                            next_st.m_bus = link.rsp_data;
                        end
                        default: begin
                            next_st.m_err = link.rsp_data;
                        end
                    endcase
                    next_st.state = usbd_pkg::USBD_ST_IDLE;
                end
            end
        endcase

        // Software reads
        if (i_rd) begin
            unique case (i_addr)
                `USBD_SW_CMD: begin
                    next_st.rdata = {9'h000, st.err_pend, st.bd_pend, st.cfg[1:0], st.cfg[2],
                                     st.res_on, st.rst_on};
                end
                `USBD_SW_BD: begin
                    next_st.rdata = st.m_bd;
                end
                `USBD_SW_ERR: begin
                    next_st.rdata = st.m_err;
                end
                default: begin
                    next_st.rdata = st.m_bus;
                end
            endcase
        end
    end

    // ======================================================================
    // Registers
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st       <= '0;
            st.state <= usbd_pkg::USBD_ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;

endmodule : usbd_ctrl

// ==== src/usbd_ctrl_note.sv ====
// Holds no logic: the controller end is complete in its own module

// ==== tb/usbd_assertions.sv ====
// Link checker between the controller end and the device end
module usbd_assertions (
    input wire logic                 i_clock,
    input wire logic                 i_nrst,
    input wire logic                 req_valid,
    input wire logic                 req_ready,
    input wire logic                 req_write,
    input wire logic [1:0]           req_addr,
    input wire usbd_pkg::usbd_word_t req_wdata,
    input wire logic                 rsp_valid,
    input wire logic                 rsp_ready,
    input wire usbd_pkg::usbd_word_t rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Handshake and answer properties
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    wire rtake = req_valid && req_ready && !req_write;
    wire wtake = req_valid && req_ready && req_write;
    read_answer_a: assert property (rtake |-> ##[1:2] rsp_valid) else $error("read not answered");
    write_silent_a: assert property (wtake && !rsp_valid |=> !rsp_valid) else $error("write answered");
    // Empty buffer at the take, so the next head is this answer
    err_unused_a: assert property (rtake && req_addr == 2'h2 && !rsp_valid
        |=> rsp_data[15:8] == 8'h0 && !rsp_data[6]) else $error("error word unused bits set");
    bus_unused_a: assert property (rtake && req_addr == 2'h1 && !rsp_valid
        |=> rsp_data[15:8] == 8'h0) else $error("bus word unused bits set");
    full_refuse_a: assert property (!req_ready |-> rsp_valid && !rsp_ready) else $error("refused while not full");
    rsp_cause_a: assert property ($rose(rsp_valid) |-> $past(rtake)) else $error("answer without read");
    rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("answer dropped");
    req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr) && $stable(req_wdata))
        else $error("request changed while refused");
endmodule : usbd_assertions

// ==== tb/usbd_bench.sv ====
// Bench joining controller and device ends over the register link
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module usbd_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_xfer_done = 0;
    logic i_dp = 1, i_dm = 0, i_low_speed = 0, i_token_active = 0;
    logic [1:0] i_addr = 0;
    logic [15:0] i_wdata = 0, o_rdata;
    logic [3:0] i_xfer_pid = 0;
    logic [10:0] i_xfer_bytes = 0;
    logic [6:0] err_in = 0;
    logic o_owned, o_data1, o_token_reject, o_reset_drive, o_resume_drive, o_host_en, o_pp_clear, o_sof_en;
    logic [9:0] o_byte_count;
    int n_fail = 0, num_checks = 0, cyc = 0;
    initial forever #12.5 i_clock = ~i_clock;
    usbd_if u_link();
    // Short timer counts keep the run brief
    usbd_ctrl #(.RESET_CYCLES(20), .RESUME_CYCLES(10)) i_usbd_ctrl (.i_clock, .i_nrst, .link(u_link),
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
    usbd_device i_usbd_device (.i_clock, .i_nrst, .link(u_link), .i_dp, .i_dm, .i_low_speed, .i_token_active,
        .i_xfer_done, .i_xfer_pid, .i_xfer_bytes, .i_err_bitstuff(err_in[6]), .i_err_turnaround(err_in[5]),
        .i_err_partial(err_in[4]), .i_err_crc16(err_in[3]), .i_err_crc5(err_in[2]), .i_err_eof(err_in[1]),
        .i_err_pid(err_in[0]), .o_owned, .o_data1, .o_byte_count, .o_token_reject, .o_reset_drive,
        .o_resume_drive, .o_host_en, .o_pp_clear, .o_sof_en);
    usbd_assertions u_chk (.i_clock, .i_nrst, .req_valid(u_link.req_valid), .req_ready(u_link.req_ready),
        .req_write(u_link.req_write), .req_addr(u_link.req_addr), .req_wdata(u_link.req_wdata),
        .rsp_valid(u_link.rsp_valid), .rsp_ready(u_link.rsp_ready), .rsp_data(u_link.rsp_data));
    // ==========================================
    // Access tasks
    task automatic idle(input int n);
        repeat (n) @(posedge i_clock);
    endtask : idle
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge i_clock); i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clock); i_wr <= 1'b0;
    endtask : wr
    // Mirrors lag the device, so callers idle before reading
    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        @(posedge i_clock); i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clock); i_rd <= 1'b0;
        #1 `CHK(o_rdata, e)
    endtask : rd
    task automatic pulse(input logic [6:0] m);
        @(posedge i_clock); err_in <= m;
        @(posedge i_clock); err_in <= 7'h0;
        #1;
    endtask : pulse
    task automatic xfer(input logic [3:0] p, input logic [10:0] n);
        @(posedge i_clock); i_xfer_done <= 1'b1; i_xfer_pid <= p; i_xfer_bytes <= n;
        @(posedge i_clock); i_xfer_done <= 1'b0;
        #1;
    endtask : xfer
    task automatic test_done;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    // ==========================================
    // Timeout
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 3000) begin n_fail++; test_done(); end
    end
    // ==========================================
    // Tests
    initial begin
        repeat (5) @(posedge i_clock);
        i_nrst <= 1'b1;
        idle(8); rd(2'h2, 16'h0000); rd(2'h3, 16'h0080);
        $display("reset values done");
        pulse(7'h7d); `CHK(o_token_reject, 1'b1)
        idle(10); rd(2'h2, 16'h009f);
        idle(20); rd(2'h2, 16'h009f);
        wr(2'h2, 16'h0005); idle(10); rd(2'h2, 16'h009a);
        wr(2'h2, 16'h0000); idle(10); rd(2'h2, 16'h009a);
        wr(2'h2, 16'hffff); idle(10); rd(2'h2, 16'h0000);
        wr(2'h0, 16'h0004); idle(10); pulse(7'h02); idle(10); rd(2'h2, 16'h0002);
        pulse(7'h04); `CHK(o_token_reject, 1'b0)
        wr(2'h2, 16'h0002); wr(2'h0, 16'h0000); idle(10); rd(2'h2, 16'h0000);
        $display("error flags done");
        wr(2'h1, 16'h840a); idle(10); `CHK({o_owned, o_data1, o_byte_count}, 12'h80a)
        wr(2'h1, 16'h0005); idle(10); `CHK(o_byte_count, 10'h00a)
        xfer(4'h9, 11'd6); `CHK({o_owned, o_byte_count}, 11'h006)
        idle(10); rd(2'h1, 16'h2406);
        wr(2'h1, 16'hc00a); idle(10); `CHK(o_data1, 1'b1)
        xfer(4'h2, 11'd12); idle(10); rd(2'h1, 16'h480a); rd(2'h2, 16'h0020);
        $display("descriptor done");
        wr(2'h0, 16'h001c); idle(10); `CHK({o_host_en, o_pp_clear, o_sof_en}, 3'h7)
        @(posedge i_clock); {i_dp, i_dm, i_token_active} <= 3'b001;
        idle(10); rd(2'h3, 16'h006b);
        @(posedge i_clock); {i_dp, i_dm, i_token_active, i_low_speed} <= 4'b0101;
        idle(10); rd(2'h3, 16'h008b);
        wr(2'h0, 16'h001d); idle(6); `CHK(o_reset_drive, 1'b1)
        idle(12); `CHK(o_reset_drive, 1'b1)
        idle(8); `CHK(o_reset_drive, 1'b0)
        wr(2'h0, 16'h001e); idle(5); `CHK(o_resume_drive, 1'b1)
        idle(4); `CHK(o_resume_drive, 1'b1)
        idle(6); `CHK(o_resume_drive, 1'b0)
        wr(2'h0, 16'h0014); idle(10); `CHK({o_host_en, o_pp_clear, o_sof_en}, 3'h5)
        rd(2'h0, 16'h0014);
        $display("bus control done");
        test_done();
    end
endmodule : usbd_bench
